// File: src/fabric_csr_defs.vh
`ifndef FABRIC_CSR_DEFS_VH
`define FABRIC_CSR_DEFS_VH

// ==========================================================
// system register byte offsets (10-bit word-aligned space)
`define OFS_ACCESS_VALUE   10'h000
`define OFS_ACCESS_COMMAND 10'h004
`define OFS_FLOW_PORT0     10'h010
`define OFS_FLOW_PORT1     10'h014
`define OFS_FLOW_PORT2     10'h018
`define OFS_STATION_LO     10'h020
`define OFS_STATION_HI     10'h024
// direct window: byte 0x200..0x3FC, bit 9 marks a hit
`define WIN_HIT_BIT        9
`define WIN_SLOT_W         7

// ==========================================================
// command register field positions
`define CMD_PENDING_BIT    31
`define CMD_RNW_BIT        30
`define CMD_STEP_UP_BIT    29
`define CMD_STEP_DOWN_BIT  28
`define CMD_LANES_HI       19
`define CMD_LANES_LO       16
`define CMD_TARGET_HI      15
`define CMD_TARGET_LO      0

// ==========================================================
// reset values, widths and the window lane mask
`define LANES_ALL          4'hF
`define FLOW_W             8
`define FLOW_RESET         8'h00
`define STATION_LO_RESET   32'h00000000
`define STATION_HI_RESET   16'h0000
// upper half of the window lands at fabric 0x1800 onward
`define MAP_HI_BASE        10'h060

`endif

// File: src/fabric_window_map.v
`timescale 1ns/1ps
`include "fabric_csr_defs.vh"

// ==========================================================
// direct window slot to fabric location translation
module fabric_window_map (
   // window slot
   input  wire [`WIN_SLOT_W-1:0] slot,
   // fabric location
   output reg  [15:0]            location
);

   // only a fixed subset of the fabric space is reachable here
   always @* begin
      if (slot[`WIN_SLOT_W-1]) begin
         location = {`MAP_HI_BASE, slot[5:0]}; //RULE_09
      end else begin
         location = {10'h000, slot[5:0]}; //RULE_09
      end
   end

endmodule

// File: src/fabric_csr_indirect_write.v
`timescale 1ns/1ps
`include "fabric_csr_defs.vh"

// Summary of operation
// RULE_01 - fabric registers reachable only via bridge registers
// RULE_02 - host loads data before issuing write command
// RULE_03 - command write starts cycle, fields from command
// RULE_04 - pending stays set until fabric cycle completes
// RULE_05 - sequential mode: each data write launches write
// RULE_06 - completed sequential write steps stored target
// RULE_07 - host may chain writes without rewriting command
// RULE_08 - window write loads location, all lanes, pending
// RULE_09 - window maps fixed fabric subset via table
// RULE_10 - host observes minimum waits between accesses
// RULE_11 - direct flow control and station address registers
// RULE_12 - read command; data valid once pending clears
// RULE_13 - sequential read: data read steps, relaunches
// RULE_14 - host avoids bridge writes while pending set
module fabric_csr_indirect_write #(
   parameter ADDR_W = 10
) (
   // clock and reset
   input  wire              clk_sys,
   input  wire              sys_rst,
   // system register bus
   input  wire [ADDR_W-1:0] reg_addr,
   input  wire              reg_wr,
   input  wire              reg_rd,
   input  wire [31:0]       reg_wdata,
   output reg  [31:0]       reg_rdata,
   output reg               reg_rvalid,
   // fabric register port
   output reg               fab_req,
   output wire              fab_we,
   output wire [15:0]       fab_addr,
   output wire [3:0]        fab_be,
   output wire [31:0]       fab_wdata,
   input  wire              fab_ack,
   input  wire [31:0]       fab_rdata,
   // direct fabric configuration
   output reg  [`FLOW_W-1:0] flow_port0,
   output reg  [`FLOW_W-1:0] flow_port1,
   output reg  [`FLOW_W-1:0] flow_port2,
   output wire [47:0]       station_addr
);

   // =======================================================
   // state
   reg        cycle_pending;
   reg        read_not_write;
   reg        step_up;
   reg        step_down;
   reg [3:0]  byte_lane_enables;
   reg [15:0] target_location;
   reg [31:0] fabric_access_value;
   reg [31:0] station_lo;
   reg [15:0] station_hi;
   reg [31:0] next_rdata;

   wire [`WIN_SLOT_W-1:0] win_slot;
   wire [15:0]            win_location;
   wire                   win_hit;
   wire                   stepping;
   wire                   hit_value;
   wire                   hit_cmd;
   wire [31:0]            fabric_access_command;

   assign win_slot = reg_addr[`WIN_SLOT_W+1:2];
   assign win_hit  = reg_addr[`WIN_HIT_BIT];
   assign stepping = step_up | step_down;
   assign hit_value = (reg_addr == `OFS_ACCESS_VALUE);
   assign hit_cmd   = (reg_addr == `OFS_ACCESS_COMMAND);

   assign fabric_access_command = {cycle_pending, read_not_write,
                                   step_up, step_down, 8'h00,
                                   byte_lane_enables,
                                   target_location};

   // fabric port is driven straight from the held command
   // no extra stage: the fields are flops already and stay frozen
   // while a cycle is pending, so the port adds no latency
   assign fab_we       = ~read_not_write;
   assign fab_addr     = target_location;
   assign fab_be       = byte_lane_enables;
   assign fab_wdata    = fabric_access_value;
   assign station_addr = {station_hi, station_lo};

   // =======================================================
   // address stepping
   // wraps silently at both ends of the 16-bit location space
   function [15:0] stepped;
      input [15:0] loc;
      input        down;
      begin
         if (down) begin
            stepped = loc - 16'h0001;
         end else begin
            stepped = loc + 16'h0001;
         end
      end
   endfunction

   fabric_window_map u_map (
      .slot     (win_slot),
      .location (win_location)
   );

   // =======================================================
   // register read mux, one cycle latency
   // window reads answer zero: the window is write-only
   always @* begin
      next_rdata = 32'h00000000;
      if (hit_value) begin
         next_rdata = fabric_access_value; //RULE_12
      end else if (hit_cmd) begin
         next_rdata = fabric_access_command; //RULE_04
      end else if (reg_addr == `OFS_FLOW_PORT0) begin
         next_rdata = {24'h000000, flow_port0};
      end else if (reg_addr == `OFS_FLOW_PORT1) begin
         next_rdata = {24'h000000, flow_port1};
      end else if (reg_addr == `OFS_FLOW_PORT2) begin
         next_rdata = {24'h000000, flow_port2};
      end else if (reg_addr == `OFS_STATION_LO) begin
         next_rdata = station_lo;
      end else if (reg_addr == `OFS_STATION_HI) begin
         next_rdata = {16'h0000, station_hi};
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata  <= 32'h00000000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   // =======================================================
   // directly mapped configuration
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         flow_port0 <= `FLOW_RESET;
         flow_port1 <= `FLOW_RESET;
         flow_port2 <= `FLOW_RESET;
         station_lo <= `STATION_LO_RESET;
         station_hi <= `STATION_HI_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `OFS_FLOW_PORT0: flow_port0 <= reg_wdata[`FLOW_W-1:0]; //RULE_11
            `OFS_FLOW_PORT1: flow_port1 <= reg_wdata[`FLOW_W-1:0]; //RULE_11
            `OFS_FLOW_PORT2: flow_port2 <= reg_wdata[`FLOW_W-1:0]; //RULE_11
            `OFS_STATION_LO: station_lo <= reg_wdata; //RULE_11
            `OFS_STATION_HI: station_hi <= reg_wdata[15:0]; //RULE_11
            default: begin
            end
         endcase
      end
   end

   // =======================================================
   // indirect access engine
   // bridge writes during a pending cycle are dropped so the held
   // command and data can never change under the fabric
   // pending and request always rise and fall together
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cycle_pending       <= 1'b0;
         read_not_write      <= 1'b0;
         step_up             <= 1'b0;
         step_down           <= 1'b0;
         byte_lane_enables   <= 4'h0;
         target_location     <= 16'h0000;
         fabric_access_value <= 32'h00000000;
         fab_req             <= 1'b0;
      end else if (fab_req) begin
         if (fab_ack) begin
            fab_req       <= 1'b0;
            cycle_pending <= 1'b0; //RULE_04
            if (read_not_write) begin
               fabric_access_value <= fab_rdata; //RULE_12
            end else if (stepping) begin
               target_location <= stepped(target_location,
                                          step_down); //RULE_06
            end
         end
      end else if (reg_wr && win_hit) begin
         // step bits are kept, so a window write made in sequential
         // mode still steps the location; software clears them first
         target_location     <= win_location; //RULE_08
         byte_lane_enables   <= `LANES_ALL; //RULE_08
         read_not_write      <= 1'b0; //RULE_08
         fabric_access_value <= reg_wdata;
         cycle_pending       <= 1'b1; //RULE_08
         fab_req             <= 1'b1; //RULE_01
      end else if (reg_wr && hit_cmd) begin
         read_not_write    <= reg_wdata[`CMD_RNW_BIT]; //RULE_03
         step_up           <= reg_wdata[`CMD_STEP_UP_BIT]; //RULE_05
         step_down         <= reg_wdata[`CMD_STEP_DOWN_BIT]; //RULE_05
         byte_lane_enables <= reg_wdata[`CMD_LANES_HI:`CMD_LANES_LO]; //RULE_03
         target_location   <=
            reg_wdata[`CMD_TARGET_HI:`CMD_TARGET_LO]; //RULE_03
         if (reg_wdata[`CMD_PENDING_BIT]) begin
            cycle_pending <= 1'b1; //RULE_03
            fab_req       <= 1'b1; //RULE_12
         end
      end else if (reg_wr && hit_value) begin
         fabric_access_value <= reg_wdata;
         if (stepping && !read_not_write) begin
            cycle_pending <= 1'b1; //RULE_05
            fab_req       <= 1'b1; //RULE_05
         end
      end else if (reg_rd && hit_value && stepping && read_not_write) begin
         // the strobe that returns this value also fetches the next one
         target_location <= stepped(target_location, step_down); //RULE_13
         cycle_pending   <= 1'b1; //RULE_13
         fab_req         <= 1'b1; //RULE_13
      end
   end

endmodule

// File: tb/fabric_csr_properties.sv
`timescale 1ns/1ps
// ==========================================================
// bridge port checker
module fabric_csr_properties #(
   parameter ADDR_W = 10
) (
   input wire              clk_sys,
   input wire              sys_rst,
   input wire [ADDR_W-1:0] reg_addr,
   input wire              reg_wr,
   input wire              reg_rd,
   input wire [31:0]       reg_wdata,
   input wire [31:0]       reg_rdata,
   input wire              reg_rvalid,
   input wire              fab_req,
   input wire              fab_we,
   input wire [15:0]       fab_addr,
   input wire [3:0]        fab_be,
   input wire [31:0]       fab_wdata,
   input wire              fab_ack,
   input wire [31:0]       fab_rdata,
   input wire [7:0]        flow_port0
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire go = reg_wr && !fab_req;
   rvalid_pulse_a: assert property (
      1'b1 |=> reg_rvalid == $past(reg_rd))
      else $error("read answer late");
   cmd_start_a: assert property (
      go && reg_addr == 10'h004 && reg_wdata[31] |=>
      fab_req && fab_addr == $past(reg_wdata[15:0])
      && fab_be == $past(reg_wdata[19:16])
      && fab_we != $past(reg_wdata[30]))
      else $error("command start wrong");
   win_start_a: assert property (
      go && reg_addr[9] |=> fab_req && fab_we && fab_be == 4'hF
      && fab_wdata == $past(reg_wdata))
      else $error("window start wrong");
   req_hold_a: assert property (
      fab_req && !fab_ack |=> fab_req
      && $stable(fab_addr) && $stable(fab_wdata))
      else $error("request moved");
   req_drop_a: assert property (
      fab_req && fab_ack |=> !fab_req)
      else $error("request kept after ack");
   pend_flag_a: assert property (
      reg_rd && reg_addr == 10'h004 |=> reg_rdata[31] == $past(fab_req))
      else $error("pending flag wrong");
   rd_capture_a: assert property (
      fab_req && fab_ack && !fab_we ##1 reg_rd && reg_addr == 10'h000
      |=> reg_rdata == $past(fab_rdata, 2))
      else $error("read value lost");
   flow_write_a: assert property (
      reg_wr && reg_addr == 10'h010 |=> flow_port0 == $past(reg_wdata[7:0]))
      else $error("flow reg wrong");
   cover property (fab_req && fab_ack && fab_we);
   cover property (fab_req && fab_ack && !fab_we);
   cover property (reg_wr && reg_addr[9]);
   cover property (reg_rd && reg_addr == 10'h000 && !fab_req
      ##1 fab_req && !fab_we);
endmodule

bind fabric_csr_indirect_write fabric_csr_properties #(
   .ADDR_W (ADDR_W)
) chk (
   .clk_sys    (clk_sys),
   .sys_rst    (sys_rst),
   .reg_addr   (reg_addr),
   .reg_wr     (reg_wr),
   .reg_rd     (reg_rd),
   .reg_wdata  (reg_wdata),
   .reg_rdata  (reg_rdata),
   .reg_rvalid (reg_rvalid),
   .fab_req    (fab_req),
   .fab_we     (fab_we),
   .fab_addr   (fab_addr),
   .fab_be     (fab_be),
   .fab_wdata  (fab_wdata),
   .fab_ack    (fab_ack),
   .fab_rdata  (fab_rdata),
   .flow_port0 (flow_port0)
);

// File: tb/fabric_partner.sv
`timescale 1ns/1ps
// ==========================================================
// fabric register file with optional slow answer
module fabric_partner (
   input  wire        clk_sys,
   input  wire        sys_rst,
   input  wire        slow,
   input  wire        fab_req,
   input  wire        fab_we,
   input  wire [15:0] fab_addr,
   input  wire [3:0]  fab_be,
   input  wire [31:0] fab_wdata,
   output reg         fab_ack,
   output reg  [31:0] fab_rdata
);
   reg  [31:0] mem [0:15];
   reg  [1:0]  wait_n;
   wire [3:0]  s = fab_addr[3:0];
   integer     i;
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fab_ack <= 1'b0;
         fab_rdata <= 32'h5A5A5A5A;
         wait_n <= 2'h0;
         for (i = 0; i < 16; i = i + 1)
            mem[i] <= 32'h00000000;
      end else begin
         fab_ack <= 1'b0;
         // data is only valid with ack, so scramble it otherwise
         fab_rdata <= ~fab_rdata;
         if (fab_req && !fab_ack && wait_n != 2'h0)
            wait_n <= wait_n - 2'h1;
         else if (fab_req && !fab_ack) begin
            fab_ack <= 1'b1;
            wait_n <= slow ? 2'h3 : 2'h0;
            if (!fab_we)
               fab_rdata <= mem[s];
            for (i = 0; i < 4; i = i + 1)
               if (fab_we && fab_be[i])
                  mem[s][8*i +: 8] <= fab_wdata[8*i +: 8];
         end
      end
   end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg         clk_sys = 1'b0;
   reg         sys_rst = 1'b1;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   reg         slow = 1'b0;
   reg  [9:0]  reg_addr = 10'h000;
   reg  [31:0] reg_wdata = 32'h00000000;
   reg  [31:0] got;
   wire [31:0] reg_rdata, fab_wdata, fab_rdata;
   wire        reg_rvalid, fab_req, fab_we, fab_ack;
   wire [15:0] fab_addr;
   wire [3:0]  fab_be;
   wire [7:0]  flow_port0, flow_port1, flow_port2;
   wire [47:0] station_addr;
   integer     n_errors = 0;
   integer     cmp_count = 0;
   integer     i, d;
   always #20 clk_sys = ~clk_sys;
   fabric_csr_indirect_write DUT (
      .clk_sys      (clk_sys),
      .sys_rst      (sys_rst),
      .reg_addr     (reg_addr),
      .reg_wr       (reg_wr),
      .reg_rd       (reg_rd),
      .reg_wdata    (reg_wdata),
      .reg_rdata    (reg_rdata),
      .reg_rvalid   (reg_rvalid),
      .fab_req      (fab_req),
      .fab_we       (fab_we),
      .fab_addr     (fab_addr),
      .fab_be       (fab_be),
      .fab_wdata    (fab_wdata),
      .fab_ack      (fab_ack),
      .fab_rdata    (fab_rdata),
      .flow_port0   (flow_port0),
      .flow_port1   (flow_port1),
      .flow_port2   (flow_port2),
      .station_addr (station_addr)
   );
   fabric_partner far_end (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .slow      (slow),
      .fab_req   (fab_req),
      .fab_we    (fab_we),
      .fab_addr  (fab_addr),
      .fab_be    (fab_be),
      .fab_wdata (fab_wdata),
      .fab_ack   (fab_ack),
      .fab_rdata (fab_rdata)
   );
   task ck(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [9:0] a, input [31:0] v);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_wdata <= v;
         reg_wr <= 1'b1;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [9:0] a);
      begin
         @(posedge clk_sys);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1 got = reg_rdata;
      end
   endtask
   // poll the pending flag, bounded so a stuck cycle cannot hang
   task idle;
      integer n;
      begin
         n = 0;
         got = 32'h80000000;
         while (got[31] !== 1'b0 && n < 20) begin
            rd(10'h004);
            n = n + 1;
         end
         if (got[31] !== 1'b0)
            n_errors = n_errors + 1;
      end
   endtask
   task frd(input [15:0] loc);
      begin
         wr(10'h004, 32'hC00F0000 | loc);
         idle;
         rd(10'h000);
      end
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      ck({flow_port0, flow_port1, flow_port2}, 32'h00000000);
      ck(station_addr[31:0], 32'h00000000);
      ck(station_addr[47:32], 32'h00000000);
      for (i = 0; i < 3; i = i + 1)
         wr(10'h010 + 4 * i, 8'h11 * (i + 1));
      wr(10'h020, 32'h89ABCDEF);
      wr(10'h024, 32'h00004567);
      #1 ck({flow_port0, flow_port1, flow_port2}, 32'h00112233);
      ck(station_addr[47:32], 32'h00004567);
      ck(station_addr[31:0], 32'h89ABCDEF);
      rd(10'h0FC);
      ck(got, 32'h00000000);
      $display("direct registers done");
      wr(10'h000, 32'h12345678);
      wr(10'h004, 32'h800F0003);
      idle;
      frd(16'h0003);
      ck(got, 32'h12345678);
      // read back in the first cycle after the answer, no polling
      wr(10'h004, 32'hC00F0003);
      @(posedge clk_sys);
      rd(10'h000);
      ck(got, 32'h12345678);
      slow <= 1'b1;
      for (d = 0; d < 2; d = d + 1) begin
         wr(10'h004, d ? 32'h100F000A : 32'h200F0004);
         for (i = 0; i < 3; i = i + 1) begin
            wr(10'h000, 32'h100 + 16 * d + i);
            idle;
         end
         rd(10'h004);
         ck(got[15:0], 16'h0007);
         for (i = 0; i < 3; i = i + 1) begin
            frd(d ? 10 - i : 4 + i);
            ck(got, 32'h100 + 16 * d + i);
         end
      end
      wr(10'h004, 32'hE00F0004);
      for (i = 0; i < 2; i = i + 1) begin
         idle;
         // leave stepping before the last value, or it fetches again
         if (i == 1)
            wr(10'h004, 32'h400F0000);
         rd(10'h000);
         ck(got, 32'h100 + i);
      end
      rd(10'h004);
      ck(got, 32'h400F0000);
      $display("indirect cycles done");
      wr(10'h204, 32'h5A5A0001);
      idle;
      ck(got, 32'h000F0001);
      wr(10'h300, 32'h5A5A1800);
      idle;
      ck(got, 32'h000F1800);
      frd(16'h0001);
      ck(got, 32'h5A5A0001);
      wr(10'h000, 32'hCAFE0002);
      wr(10'h004, 32'h80030002);
      wr(10'h000, 32'hDEAD0000);
      idle;
      frd(16'h0002);
      ck(got, 32'h00000002);
      $display("window and refusal done");
      test_done;
   end
   initial begin
      #400000;
      n_errors = n_errors + 1;
      test_done;
   end
   task test_done;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
endmodule
